// *** src/core_pkg.sv ***
// Shared constants, types and decode helpers for the core control block.
// Assumes one core clock; all users reference items as core_pkg::name.

package core_pkg;

  // ==========================================================================
  // Sizes and addresses
  localparam int          NUM_SRC      = 13;
  localparam int          PC_W         = 11;
  localparam int          MEM_DEPTH    = 192;
  localparam logic [10:0] RESET_VECTOR = 11'h000;
  localparam logic [10:0] FIRST_VECTOR = 11'h001;
  localparam logic [15:0] IO_BASE      = 16'h0020;
  localparam logic [15:0] SRAM_BASE    = 16'h0060;
  localparam logic [15:0] DATA_END     = 16'h00e0;
  localparam logic [15:0] SP_DATA_ADDR = 16'h005d;
  localparam logic [5:0]  SP_IO_ADDR   = 6'h3d;
  localparam logic [7:0]  SP_RESET     = 8'h00;
  localparam logic [4:0]  PTR_X_LO     = 5'h1a;
  localparam logic [4:0]  IMM_REG_BASE = 5'h10;

  // ==========================================================================
  // Types
  typedef enum logic [10:0] {
    OP_ALU_RR = 11'h001, OP_ALU_RI = 11'h002, OP_LOAD  = 11'h004,
    OP_STORE  = 11'h008, OP_PUSH   = 11'h010, OP_POP   = 11'h020,
    OP_CALL   = 11'h040, OP_RET    = 11'h080, OP_INTERRUPT_RETURN  = 11'h100,
    OP_SEI    = 11'h200, OP_CLI    = 11'h400
  } op_t;

  typedef enum logic [7:0] {
    ALU_ADD = 8'h01, ALU_SUB = 8'h02, ALU_SBC = 8'h04, ALU_AND = 8'h08,
    ALU_OR  = 8'h10, ALU_XOR = 8'h20, ALU_MOV = 8'h40, ALU_CMP = 8'h80
  } alu_t;

  typedef enum logic [4:0] {
    AM_DIRECT = 5'h01, AM_INDIRECT = 5'h02, AM_DISP = 5'h04,
    AM_PREDEC = 5'h08, AM_POSTINC  = 5'h10
  } mode_t;

  typedef enum logic [4:0] {
    SP_HOLD = 5'h01, SP_DEC1 = 5'h02, SP_DEC2 = 5'h04,
    SP_INC1 = 5'h08, SP_INC2 = 5'h10
  } sp_adj_t;

  typedef struct packed {
    op_t         op;
    alu_t        alu;
    mode_t       mode;
    logic [1:0]  ptrSel;
    logic [4:0]  rd;
    logic [4:0]  rr;
    logic [7:0]  imm;
    logic [5:0]  disp;
    logic [7:0]  addr;
    logic [10:0] target;
    logic        twoWord;
  } cmd_t;

  typedef struct packed {
    logic pin;
    logic powerOn;
    logic brownOut;
    logic watchdog;
  } reset_src_t;

  typedef struct packed {
    logic        en;
    logic [15:0] addr;
    logic [7:0]  data;
  } wr_port_t;

  // ==========================================================================
  // Data-space decode
  function automatic logic is_reg(input logic [15:0] a);
    return a < IO_BASE;
  endfunction

  function automatic logic is_mem(input logic [15:0] a);
    return (a >= IO_BASE) && (a < DATA_END);
  endfunction

  function automatic logic [7:0] mem_index(input logic [15:0] a);
    return 8'(a - IO_BASE);
  endfunction

endpackage

// *** src/core_vector_stack_dataspace.sv ***
// Core control: reset/interrupt vectoring, stack, data space, one-cycle ALU.
// Assumes one command per cycle from the sequencer and peripherals holding
// their requests until acknowledged.
`timescale 1ns/100ps

module core_vector_stack_dataspace (
  input  wire logic                 ref_clk,
  input  wire logic                 rst_n,
  input  core_pkg::reset_src_t      resetSources,
  input  wire logic [12:0]          reqLines,
  input  wire logic [12:0]          srcEnable,
  input  wire logic                 cmdValid,
  input  core_pkg::cmd_t            cmd,
  output logic                      cmdReady,
  output logic                      irqAck,
  output logic [3:0]                irqAckIdx,
  output logic [10:0]               progCounter,
  output logic [7:0]                stackPtr,
  output logic                      globalEnable,
  output logic                      carryFlag,
  output logic                      zeroFlag,
  output logic [7:0]                resultData
);

  // ==========================================================================
  // State
  logic [7:0]          regFile_q [32];
  logic [7:0]          dataMem_q [core_pkg::MEM_DEPTH];
  logic [10:0]         pc_q;
  logic [10:0]         pc_d;
  logic                ge_q;
  logic                ge_d;
  logic                carry_q;
  logic                carry_d;
  logic                zero_q;
  logic                zero_d;
  logic [7:0]          result_q;
  logic [7:0]          result_d;
  logic                irqAck_q;
  logic [3:0]          irqAckIdx_q;

  logic                resetReq;
  logic                irqTake;
  logic [3:0]          irqIdx;
  logic [10:0]         irqVector;
  logic                exec;
  logic [7:0]          sp;
  logic                spWr;
  core_pkg::sp_adj_t   spAdj;
  core_pkg::wr_port_t  portA;
  core_pkg::wr_port_t  portB;
  logic                regWr;
  logic [4:0]          regIdx;
  logic [7:0]          regData;
  logic                ptrUpd;
  logic [4:0]          ptrLoIdx;
  logic [15:0]         ptrVal;
  logic [15:0]         effAddr;
  logic [15:0]         newPtr;
  logic [4:0]          immIdx;
  logic [7:0]          opB;
  logic [8:0]          aluRes;
  logic [10:0]         pcStep;
  logic [7:0]          popHigh;
  logic [7:0]          popLow;

  // ==========================================================================
  // Helpers
  function automatic logic [7:0] ds_read(input logic [15:0] a);
    logic [7:0] v;
    v = 8'h00;
    if (core_pkg::is_reg(a)) begin
      v = regFile_q[a[4:0]];
    end else if (a == core_pkg::SP_DATA_ADDR) begin
      v = sp;
    end else if (core_pkg::is_mem(a)) begin
      v = dataMem_q[core_pkg::mem_index(a)];
    end
    return v;
  endfunction

  // Carry bit holds the borrow for subtract forms
  function automatic logic [8:0] alu_calc(input core_pkg::alu_t f,
                                          input logic [7:0] a,
                                          input logic [7:0] b,
                                          input logic       cin);
    logic [8:0] r;
    r = 9'h000;
    case (f)
      core_pkg::ALU_ADD: r = {1'b0, a} + {1'b0, b};
      core_pkg::ALU_SUB: r = {1'b0, a} - {1'b0, b};
      core_pkg::ALU_CMP: r = {1'b0, a} - {1'b0, b};
      core_pkg::ALU_SBC: r = {1'b0, a} - {1'b0, b} - {8'h00, cin};
      core_pkg::ALU_AND: r = {1'b0, a & b};
      core_pkg::ALU_OR:  r = {1'b0, a | b};
      core_pkg::ALU_XOR: r = {1'b0, a ^ b};
      core_pkg::ALU_MOV: r = {1'b0, b};
      default:           r = {1'b0, a};
    endcase
    return r;
  endfunction

  // ==========================================================================
  // Submodules
  irq_arbiter u_arbiter (
    .reqLines     (reqLines),
    .srcEnable    (srcEnable),
    .globalEnable (ge_q),
    .take         (irqTake),
    .srcIdx       (irqIdx),
    .vector       (irqVector)
  );

  stack_unit u_stack (
    .ref_clk  (ref_clk),
    .rst_n    (rst_n),
    .wrEn     (spWr),
    .wrData   (regFile_q[cmd.rd]),
    .adjust   (spAdj),
    .stackPtr (sp)
  );

  // ==========================================================================
  // Operand and address path
  assign resetReq = |resetSources;
  assign cmdReady = !resetReq && !irqTake;
  assign exec     = cmdValid && cmdReady;

  assign ptrLoIdx = core_pkg::PTR_X_LO + {2'b00, cmd.ptrSel, 1'b0};
  assign ptrVal   = {regFile_q[ptrLoIdx + 5'h01],
                     regFile_q[ptrLoIdx]};

  always_comb begin
    effAddr = ptrVal;
    newPtr  = ptrVal;
    unique case (cmd.mode)
      core_pkg::AM_DIRECT:   effAddr = {8'h00, cmd.addr};
      core_pkg::AM_INDIRECT: effAddr = ptrVal;
      core_pkg::AM_DISP:     effAddr = ptrVal + {10'h000, cmd.disp};
      core_pkg::AM_PREDEC: begin
        effAddr = ptrVal - 16'h0001;
        newPtr  = ptrVal - 16'h0001;
      end
      core_pkg::AM_POSTINC: begin
        effAddr = ptrVal;
        newPtr  = ptrVal + 16'h0001;
      end
      default:               effAddr = ptrVal;
    endcase
  end

  // Immediate forms can only name the upper half of the file
  assign immIdx  = core_pkg::IMM_REG_BASE | {1'b0, cmd.rd[3:0]};
  assign opB     = (cmd.op == core_pkg::OP_ALU_RI) ? cmd.imm
                                                   : regFile_q[cmd.rr];
  assign aluRes  = alu_calc(cmd.alu,
                            (cmd.op == core_pkg::OP_ALU_RI) ?
                              regFile_q[immIdx] : regFile_q[cmd.rd],
                            opB, carry_q);
  assign pcStep  = pc_q + (cmd.twoWord ? 11'h002 : 11'h001);
  // Process form: a stack write alone must re-evaluate the pop reads
  always_comb begin
    popHigh = ds_read({8'h00, sp} + 16'h0001);
    popLow  = ds_read({8'h00, sp} + 16'h0002);
  end

  // ==========================================================================
  // Sequencing: reset beats interrupt beats command
  always_comb begin
    pc_d     = pc_q;
    ge_d     = ge_q;
    carry_d  = carry_q;
    zero_d   = zero_q;
    result_d = result_q;
    spWr     = 1'b0;
    spAdj    = core_pkg::SP_HOLD;
    portA    = '0;
    portB    = '0;
    regWr    = 1'b0;
    regIdx   = cmd.rd;
    regData  = 8'h00;
    ptrUpd   = 1'b0;
    if (resetReq) begin
      pc_d = core_pkg::RESET_VECTOR;
      ge_d = 1'b0;
    end else if (irqTake) begin
      portA = '{en: 1'b1, addr: {8'h00, sp}, data: pc_q[7:0]};
      portB = '{en: 1'b1, addr: {8'h00, sp} - 16'h0001,
                data: {5'h00, pc_q[10:8]}};
      spAdj = core_pkg::SP_DEC2;
      pc_d  = irqVector;
      ge_d  = 1'b0;
    end else if (exec) begin
      pc_d = pcStep;
      unique case (cmd.op)
        core_pkg::OP_ALU_RR, core_pkg::OP_ALU_RI: begin
          regIdx   = (cmd.op == core_pkg::OP_ALU_RI) ? immIdx : cmd.rd;
          regWr    = (cmd.alu != core_pkg::ALU_CMP);
          regData  = aluRes[7:0];
          carry_d  = aluRes[8];
          zero_d   = (aluRes[7:0] == 8'h00);
          result_d = aluRes[7:0];
        end
        core_pkg::OP_LOAD: begin
          regWr    = 1'b1;
          regData  = ds_read(effAddr);
          result_d = regData;
          ptrUpd   = cmd.mode inside {core_pkg::AM_PREDEC,
                                      core_pkg::AM_POSTINC};
        end
        core_pkg::OP_STORE: begin
          portA  = '{en: 1'b1, addr: effAddr, data: regFile_q[cmd.rd]};
          spWr   = (effAddr == core_pkg::SP_DATA_ADDR);
          ptrUpd = cmd.mode inside {core_pkg::AM_PREDEC,
                                    core_pkg::AM_POSTINC};
        end
        core_pkg::OP_PUSH: begin
          portA = '{en: 1'b1, addr: {8'h00, sp}, data: regFile_q[cmd.rd]};
          spAdj = core_pkg::SP_DEC1;
        end
        core_pkg::OP_POP: begin
          regWr    = 1'b1;
          regData  = popHigh;
          result_d = popHigh;
          spAdj    = core_pkg::SP_INC1;
        end
        core_pkg::OP_CALL: begin
          portA = '{en: 1'b1, addr: {8'h00, sp}, data: pcStep[7:0]};
          portB = '{en: 1'b1, addr: {8'h00, sp} - 16'h0001,
                    data: {5'h00, pcStep[10:8]}};
          spAdj = core_pkg::SP_DEC2;
          pc_d  = cmd.target;
        end
        core_pkg::OP_RET, core_pkg::OP_INTERRUPT_RETURN: begin
          spAdj = core_pkg::SP_INC2;
          pc_d  = {popHigh[2:0], popLow};
          if (cmd.op == core_pkg::OP_INTERRUPT_RETURN) begin
            ge_d = 1'b1;
          end
        end
        core_pkg::OP_SEI: ge_d = 1'b1;
        core_pkg::OP_CLI: ge_d = 1'b0;
        default:          pc_d = pc_q;
      endcase
    end
  end

  // ==========================================================================
  // Control registers
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      pc_q     <= core_pkg::RESET_VECTOR;
      ge_q     <= 1'b0;
      carry_q  <= 1'b0;
      zero_q   <= 1'b0;
      result_q <= 8'h00;
    end else begin
      pc_q     <= pc_d;
      ge_q     <= ge_d;
      carry_q  <= carry_d;
      zero_q   <= zero_d;
      result_q <= result_d;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      irqAck_q    <= 1'b0;
      irqAckIdx_q <= 4'h0;
    end else begin
      irqAck_q    <= irqTake && !resetReq;
      irqAckIdx_q <= irqIdx;
    end
  end

  // ==========================================================================
  // Storage: pointer update written last, so it wins over a same-cycle store
  always_ff @(posedge ref_clk) begin
    if (portA.en && core_pkg::is_reg(portA.addr)) begin
      regFile_q[portA.addr[4:0]] <= portA.data;
    end
    if (regWr) begin
      regFile_q[regIdx] <= regData;
    end
    if (ptrUpd) begin
      regFile_q[ptrLoIdx]         <= newPtr[7:0];
      regFile_q[ptrLoIdx + 5'h01] <= newPtr[15:8];
    end
  end

  // The stack pointer location shadows plain storage
  always_ff @(posedge ref_clk) begin
    if (portA.en && core_pkg::is_mem(portA.addr)
        && portA.addr != core_pkg::SP_DATA_ADDR) begin
      dataMem_q[core_pkg::mem_index(portA.addr)] <= portA.data;
    end
    if (portB.en && core_pkg::is_mem(portB.addr)
        && portB.addr != core_pkg::SP_DATA_ADDR) begin
      dataMem_q[core_pkg::mem_index(portB.addr)] <= portB.data;
    end
  end

  assign irqAck       = irqAck_q;
  assign irqAckIdx    = irqAckIdx_q;
  assign progCounter  = pc_q;
  assign stackPtr     = sp;
  assign globalEnable = ge_q;
  assign carryFlag    = carry_q;
  assign zeroFlag     = zero_q;
  assign resultData   = result_q;

  // ==========================================================================
  // Checks
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);

  logic [12:0] pendMask;
  assign pendMask = reqLines & srcEnable;

  a_irq_priority: assert property (
    irqTake |-> (pendMask & ((13'h0001 << irqIdx) - 13'h0001)) == 13'h0000)
    else $error("lower-numbered pending source skipped");
  a_irq_gating: assert property (
    irqTake |-> ge_q && pendMask[irqIdx])
    else $error("interrupt taken while not enabled");
  a_vector_map: assert property (
    irqTake |-> irqVector == 11'(irqIdx) + 11'h001)
    else $error("vector word does not follow source order");
  a_irq_entry: assert property (
    irqTake && !resetReq |=> pc_q == $past(irqVector)
      && sp == $past(sp) - 8'h02 && !ge_q && irqAck)
    else $error("interrupt entry did not vector and push");
  a_reset_vec: assert property (
    resetReq |=> pc_q == 11'h000 && !ge_q ##1 !irqAck)
    else $error("reset source did not vector to zero");
  a_push_step: assert property (
    exec && cmd.op inside {core_pkg::OP_PUSH, core_pkg::OP_CALL}
    |=> sp == $past(sp) - (($past(cmd.op) == core_pkg::OP_PUSH) ?
                           8'h01 : 8'h02))
    else $error("push moved stack pointer wrongly");
  a_pop_step: assert property (
    exec && cmd.op inside {core_pkg::OP_POP, core_pkg::OP_RET,
                           core_pkg::OP_INTERRUPT_RETURN}
    |=> sp == $past(sp) + (($past(cmd.op) == core_pkg::OP_POP) ?
                           8'h01 : 8'h02))
    else $error("pop moved stack pointer wrongly");
  a_alu_single: assert property (
    exec && cmd.op == core_pkg::OP_ALU_RR && cmd.alu != core_pkg::ALU_CMP
    |=> regFile_q[$past(cmd.rd)] == $past(aluRes[7:0])
      && resultData == $past(aluRes[7:0]))
    else $error("register ALU result not written in one cycle");
  a_ptr_postinc: assert property (
    exec && cmd.op == core_pkg::OP_LOAD && cmd.mode == core_pkg::AM_POSTINC
    |=> {regFile_q[$past(ptrLoIdx) + 5'h01], regFile_q[$past(ptrLoIdx)]}
        == $past(ptrVal) + 16'h0001)
    else $error("pointer not advanced after post-increment");

  c_irq_taken: cover property (irqTake && !resetReq ##1 irqAck);
  c_call_ret: cover property (exec && cmd.op == core_pkg::OP_CALL
    ##[1:20] exec && cmd.op == core_pkg::OP_RET);
  c_two_pending: cover property (irqTake && $countones(pendMask) > 1);
  c_interrupt_return: cover property (exec && cmd.op == core_pkg::OP_INTERRUPT_RETURN);

endmodule

// *** src/irq_arbiter.sv ***
// Fixed-priority interrupt arbiter and vector lookup.
// Assumes request and enable lines are synchronous to the core clock.
`timescale 1ns/100ps

module irq_arbiter (
  input  wire logic [12:0] reqLines,
  input  wire logic [12:0] srcEnable,
  input  wire logic        globalEnable,
  output logic             take,
  output logic [3:0]       srcIdx,
  output logic [10:0]      vector
);

  logic [12:0] pending;

  assign pending = reqLines & srcEnable;

  // ==========================================================================
  // Priority: scan downward so the lowest index is left standing
  always_comb begin
    srcIdx = 4'h0;
    for (int i = core_pkg::NUM_SRC - 1; i >= 0; i--) begin
      if (pending[i]) begin
        srcIdx = 4'(i);
      end
    end
  end

  assign take   = globalEnable && (|pending);
  // Source order from index 0: ext request 0/1, timer1 capture, compare,
  // overflow, timer0 overflow, serial, rx, tx empty, tx done, converter,
  // nvm ready, comparator; vector word is index plus one.
  assign vector = core_pkg::FIRST_VECTOR + 11'(srcIdx);

endmodule

// *** src/stack_unit.sv ***
// Eight-bit stack pointer with direct load and signed step adjust.
// Assumes a direct load and an adjust never coincide.
`timescale 1ns/100ps

module stack_unit (
  input  wire logic              ref_clk,
  input  wire logic              rst_n,
  input  wire logic              wrEn,
  input  wire logic [7:0]        wrData,
  input  core_pkg::sp_adj_t      adjust,
  output logic [7:0]             stackPtr
);

  logic [7:0] sp_q;
  logic [7:0] sp_d;

  always_comb begin
    sp_d = sp_q;
    if (wrEn) begin
      sp_d = wrData;
    end else begin
      unique case (adjust)
        core_pkg::SP_HOLD: sp_d = sp_q;
        core_pkg::SP_DEC1: sp_d = sp_q - 8'h01;
        core_pkg::SP_DEC2: sp_d = sp_q - 8'h02;
        core_pkg::SP_INC1: sp_d = sp_q + 8'h01;
        core_pkg::SP_INC2: sp_d = sp_q + 8'h02;
        default:           sp_d = sp_q;
      endcase
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      sp_q <= core_pkg::SP_RESET;
    end else begin
      sp_q <= sp_d;
    end
  end

  assign stackPtr = sp_q;

endmodule

// *** tb/core_vector_stack_dataspace_tb_top.sv ***
// Self-checking bench for the core vector, stack and data-space block.
// Assumes the peripheral model in periph_irq_model.sv.
`timescale 1ns/100ps

module core_vector_stack_dataspace_tb_top;
  logic                 ref_clk, rst_n, cmdValid, cmdReady, irqAck;
  logic                 globalEnable, carryFlag, zeroFlag, s;
  core_pkg::reset_src_t resetSources;
  core_pkg::cmd_t       cmd;
  logic [12:0]          reqLines, srcEnable, raise, pend, r;
  logic [3:0]           irqAckIdx;
  logic [10:0]          progCounter, epc, saved;
  logic [7:0]           stackPtr, resultData, a, b, v;
  logic [8:0]           sum;
  int                   miscompares, checkCount, seed, idx, k;

  core_vector_stack_dataspace dut (.ref_clk(ref_clk), .rst_n(rst_n),
    .resetSources(resetSources), .reqLines(reqLines),
    .srcEnable(srcEnable), .cmdValid(cmdValid), .cmd(cmd),
    .cmdReady(cmdReady), .irqAck(irqAck), .irqAckIdx(irqAckIdx),
    .progCounter(progCounter), .stackPtr(stackPtr),
    .globalEnable(globalEnable), .carryFlag(carryFlag),
    .zeroFlag(zeroFlag), .resultData(resultData));
  periph_irq_model peri (.ref_clk(ref_clk), .rst_n(rst_n), .raise(raise),
    .irqAck(irqAck), .irqAckIdx(irqAckIdx), .reqLines(reqLines));

  initial begin
    ref_clk = 1'b0;
    forever #50 ref_clk = ~ref_clk;
  end

  // =========================================================================
  // Helpers
  task chk(input logic [15:0] got, input logic [15:0] exp, input string m);
    checkCount++;
    if (got !== exp) begin
      miscompares++;
      $display("BAD %0t %s", $time, m);
    end
  endtask

  function automatic core_pkg::cmd_t mk(core_pkg::op_t o,
      core_pkg::alu_t f, core_pkg::mode_t md, logic [4:0] rd,
      logic [4:0] rr, logic [7:0] imm, logic [7:0] ad);
    core_pkg::cmd_t c;
    c = '0;
    c.op = o;
    c.alu = f;
    c.mode = md;
    c.rd = rd;
    c.rr = rr;
    c.imm = imm;
    c.addr = ad;
    c.target = 11'h100;
    return c;
  endfunction

  function automatic int lowbit(logic [12:0] p);
    int l;
    l = 0;
    for (int i = 12; i >= 0; i--) if (p[i]) l = i;
    return l;
  endfunction

  // Held until taken; refusal during interrupt entry just stretches it
  task run(input core_pkg::cmd_t c);
    int n;
    n = 0;
    @(posedge ref_clk);
    cmd <= c;
    cmdValid <= 1'b1;
    @(posedge ref_clk);
    while (cmdReady !== 1'b1 && n < 20) begin
      n++;
      @(posedge ref_clk);
    end
    if (n >= 20) begin
      miscompares++;
      $display("BAD %0t command never taken", $time);
    end
    cmdValid <= 1'b0;
    epc = epc + 11'h1;
    #1;
  endtask

  task sop(input core_pkg::op_t o, input logic [4:0] rd);
    run(mk(o, core_pkg::ALU_MOV, core_pkg::AM_DIRECT, rd, 5'h0, 8'h0, 8'h0));
  endtask

  task load_immediate(input logic [4:0] rg, input logic [7:0] d);
    run(mk(core_pkg::OP_ALU_RI, core_pkg::ALU_MOV, core_pkg::AM_DIRECT, rg,
      5'h0, d, 8'h0));
  endtask

  task mem(input core_pkg::op_t o, input core_pkg::mode_t md,
      input logic [4:0] rd, input logic [7:0] ad);
    run(mk(o, core_pkg::ALU_MOV, md, rd, 5'h0, 8'h0, ad));
  endtask

  task wack(input int lim);
    s = 1'b0;
    for (int n = 0; n < lim && !s; n++) begin
      @(posedge ref_clk);
      #1;
      s = (irqAck === 1'b1);
    end
  endtask

  task close_out;
    $display("checks %0d mismatches %0d", checkCount, miscompares);
    if (miscompares == 0 && checkCount > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  // Whole run is well under 2000 cycles; allow ten times that
  initial begin
    #2000000;
    miscompares++;
    close_out;
  end

  // =========================================================================
  // Tests
  initial begin
    seed = 32'h24c51cbd;
    rst_n = 1'b0;
    resetSources = '0;
    srcEnable = '0;
    raise = '0;
    cmdValid = 1'b0;
    cmd = '0;
    epc = '0;
    pend = '0;
    repeat (16) @(posedge ref_clk);
    rst_n <= 1'b1;
    #1 chk(progCounter, 11'h000, "reset pc");
    chk(globalEnable, 1'b0, "reset enable");
    load_immediate(5'd16, 8'hc0);
    mem(core_pkg::OP_STORE, core_pkg::AM_DIRECT, 5'd16, 8'h5d);
    chk(stackPtr, 8'hc0, "sp store");
    v = 8'($random(seed));
    load_immediate(5'd16, v);
    sop(core_pkg::OP_PUSH, 5'd16);
    chk(stackPtr, 8'hbf, "push");
    sop(core_pkg::OP_POP, 5'd20);
    chk(stackPtr, 8'hc0, "pop");
    chk(resultData, v, "pop data");
    sop(core_pkg::OP_CALL, 5'd0);
    saved = epc;
    chk(progCounter, 11'h100, "call pc");
    chk(stackPtr, 8'hbe, "call sp");
    sop(core_pkg::OP_RET, 5'd0);
    chk(stackPtr, 8'hc0, "ret sp");
    chk(progCounter, saved, "ret pc");
    epc = saved;
    $display("stack test done");
    load_immediate(5'd26, 8'h70);
    load_immediate(5'd27, 8'h00);
    mem(core_pkg::OP_STORE, core_pkg::AM_POSTINC, 5'd16, 8'h0);
    mem(core_pkg::OP_LOAD, core_pkg::AM_DIRECT, 5'd17, 8'h70);
    chk(resultData, v, "direct load");
    mem(core_pkg::OP_LOAD, core_pkg::AM_PREDEC, 5'd18, 8'h0);
    chk(resultData, v, "predec load");
    $display("data test done");
    for (k = 0; k < 5; k++) begin
      a = (k == 0) ? 8'hff : 8'($random(seed));
      b = (k == 0) ? 8'h01 : 8'($random(seed));
      load_immediate(5'd16, a);
      load_immediate(5'd17, b);
      run(mk(core_pkg::OP_ALU_RR, core_pkg::ALU_ADD, core_pkg::AM_DIRECT,
        5'd16, 5'd17, 8'h0, 8'h0));
      sum = {1'b0, a} + {1'b0, b};
      chk(resultData, sum[7:0], "add");
      chk(carryFlag, sum[8], "add carry");
      chk(zeroFlag, sum[7:0] == 8'h00, "add zero");
      run(mk(core_pkg::OP_ALU_RR, core_pkg::ALU_SUB, core_pkg::AM_DIRECT,
        5'd16, 5'd17, 8'h0, 8'h0));
      chk(resultData, a, "sub");
      chk(carryFlag, sum[7:0] < b, "sub borrow");
      chk(zeroFlag, a == 8'h00, "sub zero");
    end
    $display("alu test done");
    @(posedge ref_clk);
    srcEnable <= 13'h1ffe;
    raise <= 13'h0001;
    @(posedge ref_clk) raise <= '0;
    pend = 13'h0001;
    sop(core_pkg::OP_SEI, 5'd0);
    wack(6);
    chk(s, 1'b0, "masked source");
    sop(core_pkg::OP_CLI, 5'd0);
    @(posedge ref_clk) srcEnable <= '1;
    wack(6);
    chk(s, 1'b0, "global off");
    sop(core_pkg::OP_SEI, 5'd0);
    for (k = 0; k < 60 && pend != 0; k++) begin
      saved = epc;
      wack(10);
      idx = lowbit(pend);
      chk(s, 1'b1, "ack seen");
      chk(16'(irqAckIdx), 16'(idx), "priority");
      chk(progCounter, 11'(idx + 1), "vector");
      chk(stackPtr, 8'hbe, "entry sp");
      pend = pend & ~(13'h1 << idx);
      r = (k < 13) ? (13'h1 << k) | 13'($random(seed)) : '0;
      @(posedge ref_clk) raise <= r;
      @(posedge ref_clk) raise <= '0;
      pend = pend | r;
      sop(core_pkg::OP_INTERRUPT_RETURN, 5'd0);
      chk(stackPtr, 8'hc0, "interrupt_return sp");
      chk(progCounter, saved, "interrupt_return pc");
      chk(globalEnable, 1'b1, "interrupt_return enable");
      epc = saved;
    end
    chk(16'(pend), 16'h0000, "all served");
    $display("interrupt test done");
    for (k = 0; k < 4; k++) begin
      sop(core_pkg::OP_PUSH, 5'd16);
      @(posedge ref_clk) resetSources <= core_pkg::reset_src_t'(4'h1 << k);
      @(posedge ref_clk) resetSources <= '0;
      #1 chk(progCounter, 11'h000, "reset source");
      chk(globalEnable, 1'b0, "reset source enable");
      epc = '0;
    end
    $display("reset test done");
    close_out;
  end
endmodule

// *** tb/periph_irq_model.sv ***
// Peripherals that raise interrupt requests towards the core.
// Assumes the bench pulses raise for one cycle per event.
`timescale 1ns/100ps

module periph_irq_model (
  input  wire logic        ref_clk,
  input  wire logic        rst_n,
  input  wire logic [12:0] raise,
  input  wire logic        irqAck,
  input  wire logic [3:0]  irqAckIdx,
  output logic [12:0]      reqLines
);
  // Request held until its own acknowledge, like a peripheral flag
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      reqLines <= '0;
    end else begin
      reqLines <= (reqLines | raise) & ~(irqAck ? 13'h1 << irqAckIdx : '0);
    end
  end
endmodule
